/* hdl/rtu_frame_pkg.sv */
`default_nettype none
package rtu_frame_pkg;
    // reference clock, at least nine cycles per received byte
    localparam int CLK_PERIOD_NS = 8;
    // least line silence that bounds a frame
    localparam int QUIET_TIME_NS = 50_000_000;
    localparam int QUIET_CYCLES = QUIET_TIME_NS / CLK_PERIOD_NS;
    localparam int QUIET_CNT_W = 24;

    // frame check
    localparam logic [15:0] CHECK_PRESET = 16'hffff;
    localparam logic [15:0] CHECK_POLY = 16'ha001;
    localparam logic [3:0] CHECK_STEPS = 4'h8;

    // frame layout
    localparam logic [8:0] IDX_ADDR = 9'h000;
    localparam logic [8:0] IDX_OPCODE = 9'h001;
    localparam logic [8:0] IDX_LENGTH = 9'h002;
    localparam logic [8:0] HEADER_BYTES = 9'h003;
    localparam logic [8:0] OVERHEAD_BYTES = 9'h005;
    localparam logic [8:0] IDX_MAX = 9'h1ff;

    // station addresses
    localparam logic [7:0] ADDR_BROADCAST = 8'h00;
    localparam logic [7:0] ADDR_MIN = 8'h01;
    localparam logic [7:0] ADDR_MAX = 8'hfa;

    // character format selector values
    localparam logic [2:0] FMT_NONE = 3'h3;
    localparam logic [2:0] FMT_EVEN = 3'h4;
    localparam logic [2:0] FMT_ODD = 3'h5;

    localparam int TX_FIFO_DEPTH = 8;

    typedef enum logic [1:0] {
        FIELD_ADDR,
        FIELD_OPCODE,
        FIELD_LENGTH,
        FIELD_DATA
    } field_kind_t;

    typedef struct packed {
        field_kind_t kind;
        logic [7:0] data;
    } rx_byte_t;

    typedef struct packed {
        logic last;
        logic [7:0] data;
    } tx_word_t;

    typedef struct packed {
        logic valid;
        logic parity_en;
        logic parity_odd;
    } char_format_t;
endpackage
`default_nettype wire

/* hdl/rtu_tx_fifo.sv */
`default_nettype none
module rtu_tx_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic [AW:0] count_next;
    logic wr;
    logic load;

    assign wr = in_valid_i && in_ready_o;
    // output stage refills when empty or being taken
    assign load = (count_reg != '0) && (!out_valid_o || out_ready_i);

    always_comb begin
        count_next = count_reg;
        if (wr && !load) begin
            count_next = count_reg + 1'b1;
        end else if (!wr && load) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (wr) begin
            mem[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            in_ready_o <= 1'b1;
        end else begin
            if (wr) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (load) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            count_reg <= count_next;
            in_ready_o <= count_next != (AW + 1)'(DEPTH);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_valid_o <= 1'b0;
            out_data_o <= '0;
        end else if (load) begin
            out_valid_o <= 1'b1;
            out_data_o <= mem[rd_ptr_reg];
        end else if (out_ready_i) begin
            out_valid_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* hdl/rtu_frame_crc16.sv */
// Overview of operation
// - frames are bounded by more than 50 ms of line silence, kept before and after each reply.
// - the first byte after the silence is the station address.
// - the second byte is the operation code.
// - the third byte gives the count of data bytes that follow before the check field.
// - the 16-bit check register starts at all ones before the first frame byte.
// - each frame byte is XORed into the low eight bits of the check register.
// - each step shifts right with zero in on top and XORs A001 hex when a one fell out.
// - exactly eight shift steps are done per byte before the next byte is taken.
// - the check covers address, operation code, length and data bytes.
// - the check value is sent and reassembled low byte first.
// - a frame is accepted when its address equals the own address, valid from 1 to 250.
// - a frame to address zero is a broadcast, acted on and never answered.
// - format value 3 selects no parity, 4 even and 5 odd, each with one stop bit.
`default_nettype none
module rtu_frame_crc16 #(
    parameter int QUIET_CYCLES = rtu_frame_pkg::QUIET_CYCLES
) (
    input wire logic REF_CLK_I,
    input wire logic ARST_N_I,
    input wire logic [7:0] OWN_ADDRESS_I,
    input wire logic [2:0] SERIAL_FORMAT_SELECT_I,
    output rtu_frame_pkg::char_format_t CHAR_FORMAT_O,
    input wire logic RX_VALID_I,
    input wire logic [7:0] RX_DATA_I,
    output logic RX_BYTE_VALID_O,
    output rtu_frame_pkg::rx_byte_t RX_BYTE_O,
    output logic FRAME_GOOD_O,
    output logic FRAME_DROP_O,
    output logic FRAME_BROADCAST_O,
    input wire logic REPLY_VALID_I,
    input wire rtu_frame_pkg::tx_word_t REPLY_WORD_I,
    output logic REPLY_READY_O,
    output logic TX_VALID_O,
    output logic [7:0] TX_DATA_O,
    input wire logic TX_READY_I
);
    typedef enum logic [2:0] {
        TX_IDLE,
        TX_FETCH,
        TX_CALC,
        TX_SEND,
        TX_CHECK_LO,
        TX_CHECK_HI,
        TX_DRAIN
    } tx_state_t;

    localparam int QW = rtu_frame_pkg::QUIET_CNT_W;

    function automatic logic [15:0] check_step(input logic [15:0] value);
        logic [15:0] shifted;
        shifted = {1'b0, value[15:1]};
        check_step = value[0] ? (shifted ^ rtu_frame_pkg::CHECK_POLY) : shifted;
    endfunction

    // line silence
    logic [QW-1:0] quiet_cnt_reg;
    logic quiet;
    logic activity;
    logic tx_accept;

    // receive side
    logic [8:0] rx_idx_reg;
    logic [7:0] rx_addr_reg;
    logic [7:0] rx_len_reg;
    logic [7:0] rx_chk_lo_reg;
    logic [7:0] rx_chk_hi_reg;
    logic [15:0] rx_crc_reg;
    logic [3:0] rx_steps_reg;
    logic frame_open_reg;
    logic [8:0] rx_cover_end;
    logic [8:0] rx_pos;
    logic rx_covered;
    logic boundary;
    logic addr_match;
    logic frame_ok;
    logic reply_ok_reg;

    // transmit side
    tx_state_t tx_state_reg;
    logic [15:0] tx_crc_reg;
    logic [3:0] tx_steps_reg;
    logic tx_last_reg;
    logic [7:0] tx_byte_reg;
    logic fifo_valid;
    logic fifo_ready;
    rtu_frame_pkg::tx_word_t fifo_word;

    assign tx_accept = TX_VALID_O && TX_READY_I;
    assign activity = RX_VALID_I || tx_accept;
    assign quiet = quiet_cnt_reg > QW'(QUIET_CYCLES);
    assign boundary = frame_open_reg && quiet;

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            quiet_cnt_reg <= '0;
        end else if (activity) begin
            quiet_cnt_reg <= '0;
        end else if (!quiet) begin
            quiet_cnt_reg <= quiet_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            CHAR_FORMAT_O <= '0;
        end else begin
            CHAR_FORMAT_O.valid <= SERIAL_FORMAT_SELECT_I inside {rtu_frame_pkg::FMT_NONE,
                rtu_frame_pkg::FMT_EVEN, rtu_frame_pkg::FMT_ODD};
            CHAR_FORMAT_O.parity_en <= SERIAL_FORMAT_SELECT_I == rtu_frame_pkg::FMT_EVEN ||
                SERIAL_FORMAT_SELECT_I == rtu_frame_pkg::FMT_ODD;
            CHAR_FORMAT_O.parity_odd <= SERIAL_FORMAT_SELECT_I == rtu_frame_pkg::FMT_ODD;
        end
    end

    // bytes before the check field feed the check
    assign rx_cover_end = {1'b0, rx_len_reg} + rtu_frame_pkg::HEADER_BYTES;
    // a byte that meets the closing silence already opens the next frame
    assign rx_pos = boundary ? rtu_frame_pkg::IDX_ADDR : rx_idx_reg;
    assign rx_covered = (rx_pos < rtu_frame_pkg::HEADER_BYTES) ||
        (rx_pos < rx_cover_end);

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rx_idx_reg <= '0;
            rx_addr_reg <= '0;
            rx_len_reg <= '0;
            rx_chk_lo_reg <= '0;
            rx_chk_hi_reg <= '0;
            frame_open_reg <= 1'b0;
        end else if (RX_VALID_I) begin
            frame_open_reg <= 1'b1;
            if (rx_pos != rtu_frame_pkg::IDX_MAX) begin
                rx_idx_reg <= rx_pos + 1'b1;
            end
            if (rx_pos == rtu_frame_pkg::IDX_ADDR) begin
                rx_addr_reg <= RX_DATA_I;
            end
            if (rx_pos == rtu_frame_pkg::IDX_LENGTH) begin
                rx_len_reg <= RX_DATA_I;
            end
            if (rx_pos >= rtu_frame_pkg::HEADER_BYTES && rx_pos == rx_cover_end) begin
                rx_chk_lo_reg <= RX_DATA_I;
            end
            if (rx_pos >= rtu_frame_pkg::HEADER_BYTES &&
                rx_pos == rx_cover_end + 9'h001) begin
                rx_chk_hi_reg <= RX_DATA_I;
            end
        end else if (boundary) begin
            frame_open_reg <= 1'b0;
            rx_idx_reg <= '0;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rx_crc_reg <= rtu_frame_pkg::CHECK_PRESET;
            rx_steps_reg <= '0;
        end else if (RX_VALID_I && rx_covered) begin
            if (rx_pos == rtu_frame_pkg::IDX_ADDR) begin
                rx_crc_reg <= rtu_frame_pkg::CHECK_PRESET ^ {8'h00, RX_DATA_I};
            end else begin
                rx_crc_reg <= rx_crc_reg ^ {8'h00, RX_DATA_I};
            end
            rx_steps_reg <= rtu_frame_pkg::CHECK_STEPS;
        end else if (rx_steps_reg != '0) begin
            rx_crc_reg <= check_step(rx_crc_reg);
            rx_steps_reg <= rx_steps_reg - 1'b1;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            RX_BYTE_VALID_O <= 1'b0;
            RX_BYTE_O <= '0;
        end else begin
            RX_BYTE_VALID_O <= RX_VALID_I && rx_covered;
            if (RX_VALID_I) begin
                RX_BYTE_O.data <= RX_DATA_I;
                case (rx_pos)
                    rtu_frame_pkg::IDX_ADDR: RX_BYTE_O.kind <= rtu_frame_pkg::FIELD_ADDR;
                    rtu_frame_pkg::IDX_OPCODE: begin
                        RX_BYTE_O.kind <= rtu_frame_pkg::FIELD_OPCODE;
                    end
                    rtu_frame_pkg::IDX_LENGTH: RX_BYTE_O.kind <= rtu_frame_pkg::FIELD_LENGTH;
                    default: RX_BYTE_O.kind <= rtu_frame_pkg::FIELD_DATA;
                endcase
            end
        end
    end

    assign addr_match = (rx_addr_reg == rtu_frame_pkg::ADDR_BROADCAST) ||
        (rx_addr_reg == OWN_ADDRESS_I && OWN_ADDRESS_I >= rtu_frame_pkg::ADDR_MIN &&
        OWN_ADDRESS_I <= rtu_frame_pkg::ADDR_MAX);
    assign frame_ok = addr_match && rx_steps_reg == '0 &&
        rx_idx_reg >= rtu_frame_pkg::OVERHEAD_BYTES &&
        rx_idx_reg == {1'b0, rx_len_reg} + rtu_frame_pkg::OVERHEAD_BYTES &&
        rx_crc_reg == {rx_chk_hi_reg, rx_chk_lo_reg};

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            FRAME_GOOD_O <= 1'b0;
            FRAME_DROP_O <= 1'b0;
            FRAME_BROADCAST_O <= 1'b0;
        end else begin
            FRAME_GOOD_O <= boundary && frame_ok;
            FRAME_DROP_O <= boundary && !frame_ok;
            if (boundary && frame_ok) begin
                FRAME_BROADCAST_O <= rx_addr_reg == rtu_frame_pkg::ADDR_BROADCAST;
            end
        end
    end

    // a reply is sent only after a good individually addressed frame
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            reply_ok_reg <= 1'b0;
        end else if (boundary && frame_ok) begin
            reply_ok_reg <= rx_addr_reg != rtu_frame_pkg::ADDR_BROADCAST;
        end else if ((tx_state_reg == TX_CHECK_HI || tx_state_reg == TX_DRAIN) && tx_accept) begin
            reply_ok_reg <= 1'b0;
        end else if (tx_state_reg == TX_DRAIN && fifo_valid && fifo_word.last) begin
            reply_ok_reg <= 1'b0;
        end
    end

    rtu_tx_fifo #(
        .WIDTH($bits(rtu_frame_pkg::tx_word_t)),
        .DEPTH(rtu_frame_pkg::TX_FIFO_DEPTH)
    ) tx_fifo (
        .clk_i(REF_CLK_I),
        .arst_n_i(ARST_N_I),
        .in_valid_i(REPLY_VALID_I),
        .in_ready_o(REPLY_READY_O),
        .in_data_i(REPLY_WORD_I),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_ready),
        .out_data_o(fifo_word)
    );

    assign fifo_ready = tx_state_reg == TX_FETCH || tx_state_reg == TX_DRAIN;

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            tx_state_reg <= TX_IDLE;
            tx_crc_reg <= rtu_frame_pkg::CHECK_PRESET;
            tx_steps_reg <= '0;
            tx_last_reg <= 1'b0;
            tx_byte_reg <= '0;
            TX_VALID_O <= 1'b0;
            TX_DATA_O <= '0;
        end else begin
            case (tx_state_reg)
                TX_IDLE: begin
                    tx_crc_reg <= rtu_frame_pkg::CHECK_PRESET;
                    if (fifo_valid && !reply_ok_reg) begin
                        tx_state_reg <= TX_DRAIN;
                    end else if (fifo_valid && quiet && !frame_open_reg) begin
                        tx_state_reg <= TX_FETCH;
                    end
                end
                TX_FETCH: begin
                    if (fifo_valid) begin
                        tx_byte_reg <= fifo_word.data;
                        tx_last_reg <= fifo_word.last;
                        tx_crc_reg <= tx_crc_reg ^ {8'h00, fifo_word.data};
                        tx_steps_reg <= rtu_frame_pkg::CHECK_STEPS;
                        tx_state_reg <= TX_CALC;
                    end
                end
                TX_CALC: begin
                    if (tx_steps_reg != '0) begin
                        tx_crc_reg <= check_step(tx_crc_reg);
                        tx_steps_reg <= tx_steps_reg - 1'b1;
                    end else begin
                        TX_VALID_O <= 1'b1;
                        TX_DATA_O <= tx_byte_reg;
                        tx_state_reg <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    if (TX_READY_I) begin
                        if (tx_last_reg) begin
                            TX_DATA_O <= tx_crc_reg[7:0];
                            tx_state_reg <= TX_CHECK_LO;
                        end else begin
                            TX_VALID_O <= 1'b0;
                            tx_state_reg <= TX_FETCH;
                        end
                    end
                end
                TX_CHECK_LO: begin
                    if (TX_READY_I) begin
                        TX_DATA_O <= tx_crc_reg[15:8];
                        tx_state_reg <= TX_CHECK_HI;
                    end
                end
                TX_CHECK_HI: begin
                    if (TX_READY_I) begin
                        TX_VALID_O <= 1'b0;
                        tx_state_reg <= TX_IDLE;
                    end
                end
                TX_DRAIN: begin
                    if (fifo_valid && fifo_word.last) begin
                        tx_state_reg <= TX_IDLE;
                    end
                end
                default: tx_state_reg <= TX_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* verification/rtu_frame_crc16_properties.sv */
`default_nettype none
module rtu_frame_crc16_properties #(
    parameter int QUIET_CYCLES = 50
) (
    input wire logic REF_CLK_I,
    input wire logic ARST_N_I,
    input wire logic [2:0] SERIAL_FORMAT_SELECT_I,
    input wire rtu_frame_pkg::char_format_t CHAR_FORMAT_O,
    input wire logic RX_VALID_I,
    input wire logic [7:0] RX_DATA_I,
    input wire logic RX_BYTE_VALID_O,
    input wire rtu_frame_pkg::rx_byte_t RX_BYTE_O,
    input wire logic FRAME_GOOD_O,
    input wire logic FRAME_DROP_O,
    input wire logic TX_VALID_O,
    input wire logic [7:0] TX_DATA_O,
    input wire logic TX_READY_I
);
    logic [31:0] idle_reg;
    logic [31:0] line_reg;

    // cycles since the last received byte
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) idle_reg <= 32'h0;
        else if (RX_VALID_I) idle_reg <= 32'h0;
        else if (idle_reg != 32'hffffffff) idle_reg <= idle_reg + 32'h1;
    end

    // cycles since any byte moved in either direction
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) line_reg <= 32'h0;
        else if (RX_VALID_I || (TX_VALID_O && TX_READY_I)) line_reg <= 32'h0;
        else if (line_reg != 32'hffffffff) line_reg <= line_reg + 32'h1;
    end

    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!ARST_N_I);

    chk_fmt_none: assert property (SERIAL_FORMAT_SELECT_I == 3'h3
        |=> CHAR_FORMAT_O == 3'h4) else $error("format 3 decoded wrongly");
    chk_fmt_even: assert property (SERIAL_FORMAT_SELECT_I == 3'h4
        |=> CHAR_FORMAT_O == 3'h6) else $error("format 4 decoded wrongly");
    chk_fmt_odd: assert property (SERIAL_FORMAT_SELECT_I == 3'h5
        |=> CHAR_FORMAT_O == 3'h7) else $error("format 5 decoded wrongly");
    chk_fmt_other: assert property (
        SERIAL_FORMAT_SELECT_I < 3'h3 || SERIAL_FORMAT_SELECT_I > 3'h5
        |=> !CHAR_FORMAT_O.valid) else $error("unknown format marked valid");
    chk_rx_echo: assert property (RX_BYTE_VALID_O
        |-> $past(RX_VALID_I) && RX_BYTE_O.data == $past(RX_DATA_I))
        else $error("rx byte not echoed");
    chk_first_addr: assert property (RX_VALID_I && idle_reg > QUIET_CYCLES
        |=> RX_BYTE_VALID_O && RX_BYTE_O.kind == rtu_frame_pkg::FIELD_ADDR)
        else $error("first byte not shown as address");
    chk_end_quiet: assert property (FRAME_GOOD_O || FRAME_DROP_O
        |-> idle_reg > QUIET_CYCLES) else $error("frame closed before silence");
    chk_good_pulse: assert property (FRAME_GOOD_O |-> !FRAME_DROP_O ##1 !FRAME_GOOD_O)
        else $error("frame good not a single pulse");
    chk_tx_hold: assert property (TX_VALID_O && !TX_READY_I
        |=> TX_VALID_O && $stable(TX_DATA_O)) else $error("tx byte not held");
    chk_tx_quiet: assert property ($rose(TX_VALID_O)
        |-> line_reg < 32 || line_reg > QUIET_CYCLES)
        else $error("reply started without silence");
endmodule
`default_nettype wire

/* verification/rtu_host_model.sv */
`default_nettype none
module rtu_host_model (
    input wire logic clk_i,
    input wire logic stall_i,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] tx_q[$];

    initial begin
        rx_valid_o = 1'b0;
        rx_data_o = 8'h00;
        tx_ready_o = 1'b0;
    end

    // takes reply bytes unless told to stall
    always @(posedge clk_i) begin
        if (tx_valid_i && tx_ready_o) tx_q.push_back(tx_data_i);
        tx_ready_o <= !stall_i;
    end

    // bytes leave in frame order, spaced; line shows inverse data between bytes
    task automatic send(input logic [7:0] f[$]);
        foreach (f[i]) begin
            @(posedge clk_i);
            rx_valid_o <= 1'b1;
            rx_data_o <= f[i];
            @(posedge clk_i);
            rx_valid_o <= 1'b0;
            rx_data_o <= ~f[i];
            repeat (10) @(posedge clk_i);
        end
    endtask
endmodule
`default_nettype wire

/* verification/rtu_frame_crc16_tb.sv */
`default_nettype none
module rtu_frame_crc16_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int QC = 50;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] own_addr = 8'h01;
    logic [2:0] fmt_sel = 3'h0;
    logic stall = 1'b0;
    logic rep_valid = 1'b0;
    rtu_frame_pkg::tx_word_t rep_word = '0;
    logic rx_valid, tx_valid, tx_ready, rxb_valid, good, drop, bcast, rep_ready;
    logic [7:0] rx_data, tx_data;
    rtu_frame_pkg::rx_byte_t rxb;
    rtu_frame_pkg::char_format_t cfmt;
    int mismatches = 0;
    int cmp_count = 0;
    int n_good = 0;
    int n_drop = 0;
    logic full_seen = 1'b0;
    logic [9:0] rxb_q[$];

    always #4 clk = ~clk;

    rtu_frame_crc16 #(.QUIET_CYCLES(QC)) rtu_frame_crc16_inst (
        .REF_CLK_I(clk), .ARST_N_I(arst_n), .OWN_ADDRESS_I(own_addr),
        .SERIAL_FORMAT_SELECT_I(fmt_sel), .CHAR_FORMAT_O(cfmt),
        .RX_VALID_I(rx_valid), .RX_DATA_I(rx_data), .RX_BYTE_VALID_O(rxb_valid),
        .RX_BYTE_O(rxb), .FRAME_GOOD_O(good), .FRAME_DROP_O(drop), .FRAME_BROADCAST_O(bcast),
        .REPLY_VALID_I(rep_valid), .REPLY_WORD_I(rep_word), .REPLY_READY_O(rep_ready),
        .TX_VALID_O(tx_valid), .TX_DATA_O(tx_data), .TX_READY_I(tx_ready));

    rtu_host_model rtu_host_model_inst (.clk_i(clk), .stall_i(stall), .rx_valid_o(rx_valid),
        .rx_data_o(rx_data), .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready));

    always @(posedge clk) begin
        if (rxb_valid) rxb_q.push_back(rxb);
        if (good) n_good++;
        if (drop) n_drop++;
        if (!rep_ready) full_seen = 1'b1;
    end

    function automatic logic [15:0] crc16(input logic [7:0] f[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (f[i]) begin
            c[7:0] = c[7:0] ^ f[i];
            for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction

    // format struct is {valid, parity_en, parity_odd}
    function automatic logic [15:0] exp_format(input int s);
        return s == 3 ? 16'h4 : s == 4 ? 16'h6 : s == 5 ? 16'h7 : 16'h0;
    endfunction

    // byte struct is {kind, data}; kind counts 0, 1, 2 then stays at data
    function automatic logic [15:0] exp_rx_byte(input int i, input logic [7:0] d);
        return {6'h00, i > 2 ? 2'h3 : 2'(i), d};
    endfunction

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wrap_up();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic send_check(input logic [7:0] f[$], input logic exp_good, input logic cov);
        int g0, d0;
        g0 = n_good;
        d0 = n_drop;
        rxb_q.delete();
        rtu_host_model_inst.send(f);
        repeat (QC + 8) @(posedge clk);
        check("frame_good", 16'(exp_good), 16'(n_good - g0));
        check("frame_drop", 16'(!exp_good), 16'(n_drop - d0));
        if (cov) begin
            check("covered_count", 16'(f.size() - 2), 16'(rxb_q.size()));
            foreach (rxb_q[i])
                check("rx_byte", exp_rx_byte(i, f[i]), 16'(rxb_q[i]));
        end
    endtask

    task automatic run_frame(input logic [7:0] a, input logic [7:0] n, input logic [7:0] ln,
                             input logic bad, input logic exp_good, input logic cov);
        logic [7:0] f[$];
        logic [15:0] c;
        f = {a, 8'($urandom), ln};
        repeat (n) f.push_back(8'($urandom));
        c = crc16(f);
        f.push_back(c[7:0] ^ {7'h00, bad});
        f.push_back(c[15:8]);
        send_check(f, exp_good, cov);
    endtask

    task automatic push_reply(input logic [7:0] r[$]);
        foreach (r[i]) begin
            rep_valid <= 1'b1;
            rep_word <= '{last: (i == r.size() - 1), data: r[i]};
            @(posedge clk);
            for (int k = 0; k < 400 && !rep_ready; k++) @(posedge clk);
        end
        rep_valid <= 1'b0;
    endtask

    task automatic reply_check(input int n, input logic exp_sent);
        logic [7:0] r[$];
        logic [15:0] c;
        r = {own_addr, 8'($urandom), 8'(n)};
        repeat (n) r.push_back(8'($urandom));
        c = crc16(r);
        rtu_host_model_inst.tx_q.delete();
        full_seen = 1'b0;
        if (n > 8) begin
            stall <= 1'b1;
            fork
                begin
                    repeat (200) @(posedge clk);
                    stall <= 1'b0;
                end
            join_none
        end
        push_reply(r);
        for (int t = 0; t < 1500 && rtu_host_model_inst.tx_q.size() < r.size() + 2; t++)
            @(posedge clk);
        repeat (QC + 20) @(posedge clk);
        check("fifo_full", 16'(n > 8), 16'(full_seen));
        if (exp_sent) begin
            r.push_back(c[7:0]);
            r.push_back(c[15:8]);
        end else begin
            r.delete();
        end
        check("tx_count", 16'(r.size()), 16'(rtu_host_model_inst.tx_q.size()));
        foreach (r[i]) if (i < rtu_host_model_inst.tx_q.size())
            check("tx_byte", 16'(r[i]), 16'(rtu_host_model_inst.tx_q[i]));
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        wrap_up();
    end

    initial begin
        logic [7:0] a;
        logic [7:0] n;
        logic [7:0] ex[$];
        void'($urandom(32'h8492683a));
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        for (int s = 0; s < 8; s++) begin
            fmt_sel <= 3'(s);
            repeat (3) @(posedge clk);
            check("char_format", exp_format(s), 16'(cfmt));
        end
        repeat (QC + 10) @(posedge clk);
        ex = {8'h01, 8'h02, 8'h03, 8'h00, 8'h0b, 8'hb8, 8'h7f, 8'h0c};
        send_check(ex, 1'b1, 1'b1);
        check("broadcast_flag", 16'h0000, 16'(bcast));
        reply_check(9, 1'b1);
        for (int i = 0; i < 5; i++) begin
            a = i == 0 ? 8'h01 : i == 1 ? 8'hfa : 8'($urandom_range(250, 1));
            n = 8'($urandom_range(4, 0));
            own_addr <= a;
            run_frame(a, n, n, 1'b0, 1'b1, 1'b1);
            reply_check(int'(n), 1'b1);
        end
        run_frame(a, 8'h02, 8'h02, 1'b1, 1'b0, 1'b1);
        reply_check(2, 1'b0);
        run_frame(a, 8'h03, 8'h02, 1'b0, 1'b0, 1'b0);
        run_frame(a, 8'h01, 8'h02, 1'b0, 1'b0, 1'b0);
        run_frame(8'hfb - a, 8'h01, 8'h01, 1'b0, 1'b0, 1'b0);
        own_addr <= 8'hfb;
        run_frame(8'hfb, 8'h01, 8'h01, 1'b0, 1'b0, 1'b0);
        own_addr <= a;
        run_frame(8'h00, 8'h02, 8'h02, 1'b0, 1'b1, 1'b1);
        check("broadcast_flag", 16'h0001, 16'(bcast));
        reply_check(2, 1'b0);
        wrap_up();
    end
endmodule

bind rtu_frame_crc16 rtu_frame_crc16_properties #(.QUIET_CYCLES(QUIET_CYCLES))
    rtu_frame_crc16_properties_inst (
    .REF_CLK_I(REF_CLK_I), .ARST_N_I(ARST_N_I), .SERIAL_FORMAT_SELECT_I(SERIAL_FORMAT_SELECT_I),
    .CHAR_FORMAT_O(CHAR_FORMAT_O), .RX_VALID_I(RX_VALID_I), .RX_DATA_I(RX_DATA_I),
    .RX_BYTE_VALID_O(RX_BYTE_VALID_O), .RX_BYTE_O(RX_BYTE_O), .FRAME_GOOD_O(FRAME_GOOD_O),
    .FRAME_DROP_O(FRAME_DROP_O), .TX_VALID_O(TX_VALID_O), .TX_DATA_O(TX_DATA_O),
    .TX_READY_I(TX_READY_I));
`default_nettype wire
